// >>> shared/dar_consts.svh
/*
  constants of the dual channel serial readout: widths, frame layout,
  pulse counts and timing figures.
  assumes it is included by bare name wherever a constant is needed.
*/
`ifndef DAR_CONSTS_SVH
`define DAR_CONSTS_SVH

// ==========================================================
// data and frame layout
`define DAR_RES_BITS 14
`define DAR_HALF_BITS 16
`define DAR_FRAME_BITS 32
`define DAR_PAD_BITS 2
`define DAR_BITCNT_W 6
`define DAR_FRAME_LEN 6'h20
`define DAR_FRAME_LEN_M1 6'h1f

// ==========================================================
// conversion sequence
`define DAR_DONE_EDGES 6'h20

// ==========================================================
// power-down pulse counts
`define DAR_PULSE_W 3
`define DAR_NAP_PULSES 3'h2
`define DAR_SLEEP_PULSES 3'h4

// ==========================================================
// timing
`define DAR_CLK_NS 40
`define DAR_SETUP_NS 3
`define DAR_SETUP_CYC ((`DAR_SETUP_NS + `DAR_CLK_NS - 1) / `DAR_CLK_NS)
`define DAR_SETTLE_MS 2
`define DAR_SETTLE_CYC ((`DAR_SETTLE_MS * 1000000) / `DAR_CLK_NS)
`define DAR_SETTLE_W 17

`endif

// >>> shared/dar_pkg.sv
/*
  types of the dual channel serial readout.
  assumes dar_consts.svh is on the include path.
*/
`include "dar_consts.svh"

package dar_pkg;
  // ==========================================================
  // power states
  typedef enum logic [1:0] {
    dar_st_active = 2'b00, // ready for conversion
    dar_st_nap = 2'b01,    // light power-down, reference up
    dar_st_sleep = 2'b10,  // deep power-down, reference off
    dar_st_waking = 2'b11  // shift edges seen in sleep, waits for a nap request
  } dar_pwr_type;

  // one conversion result, straight binary
  typedef logic [`DAR_RES_BITS-1:0] dar_word_type;
endpackage

// >>> shared/dar_ctl_if.sv
/*
  carrier between the readout core and the power-state tracker.
  assumes both ends run on sys_clk.
*/
`timescale 1ns/1ns

interface dar_ctl_if;
  import dar_pkg::*;
  logic strobe_rise;        // synchronised strobe rising edge, one cycle
  logic shift_rise;         // synchronised shift clock rising edge, one cycle
  dar_pwr_type pwr_state;   // current power state
  logic ref_ready;          // reference settled
  modport core (output strobe_rise, output shift_rise, input pwr_state, input ref_ready);
  modport pwr (input strobe_rise, input shift_rise, output pwr_state, output ref_ready);
endinterface

// >>> verilog/dar_power.sv
/*
  power-state tracker: counts strobe pulses with no shift edge between
  them and walks active, light and deep power-down, plus reference settle.
  assumes edge pulses arrive already synchronised on sys_clk.
*/
`timescale 1ns/1ns
`include "dar_consts.svh"

module dar_power #(
  parameter int unsigned SETTLE_CYCLES = `DAR_SETTLE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link to the core
  dar_ctl_if.pwr ctl
);
  import dar_pkg::*;

  localparam logic [`DAR_SETTLE_W-1:0] SETTLE_LAST = `DAR_SETTLE_W'(SETTLE_CYCLES - 1);

  logic [`DAR_PULSE_W-1:0] pulse_q, pulse_d; // strobes since last shift edge
  dar_pwr_type state_q, state_d;
  logic [`DAR_SETTLE_W-1:0] settle_q, settle_d; // reference settle timer
  logic ready_q, ready_d;
  wire logic [`DAR_PULSE_W-1:0] pulse_inc; // saturating increment

  assign pulse_inc = (pulse_q == `DAR_SLEEP_PULSES) ? pulse_q : pulse_q + `DAR_PULSE_W'(1);

  // ==========================================================
  // pulse count: a shift edge clears it, a strobe in the same cycle counts anew
  always_comb begin
    if (ctl.shift_rise) begin
      pulse_d = ctl.strobe_rise ? `DAR_PULSE_W'(1) : '0;
    end else if (ctl.strobe_rise) begin
      pulse_d = pulse_inc;
    end else begin
      pulse_d = pulse_q;
    end
  end

  // ==========================================================
  // state walk
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dar_st_active: begin
        if (pulse_d == `DAR_SLEEP_PULSES) begin
          state_d = dar_st_sleep;
        end else if (pulse_d == `DAR_NAP_PULSES && ctl.strobe_rise) begin
          state_d = dar_st_nap;
        end
      end
      dar_st_nap: begin
        if (ctl.shift_rise) begin
          state_d = dar_st_active;
        end else if (pulse_d == `DAR_SLEEP_PULSES) begin
          state_d = dar_st_sleep;
        end
      end
      dar_st_sleep: begin
        // strobes keep it asleep; only a shift edge starts the wake
        if (ctl.shift_rise) begin
          state_d = dar_st_waking;
        end
      end
      dar_st_waking: begin
        // a nap request brings the reference back up
        if (pulse_d == `DAR_NAP_PULSES && ctl.strobe_rise) begin
          state_d = dar_st_nap;
        end
      end
    endcase
  end

  // ==========================================================
  // reference settle: restarts whenever the reference is off
  always_comb begin
    settle_d = settle_q;
    ready_d = ready_q;
    if (state_q == dar_st_sleep || state_q == dar_st_waking) begin
      settle_d = '0;
      ready_d = 1'b0;
    end else if (!ready_q) begin
      if (settle_q == SETTLE_LAST) begin
        ready_d = 1'b1;
      end else begin
        settle_d = settle_q + `DAR_SETTLE_W'(1);
      end
    end
  end

  // registers; power-up lands in active with nothing counted
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_q <= '0;
      state_q <= dar_st_active;
      settle_q <= '0;
      ready_q <= 1'b1;
    end else begin
      pulse_q <= pulse_d;
      state_q <= state_d;
      settle_q <= settle_d;
      ready_q <= ready_d;
    end
  end

  assign ctl.pwr_state = state_q;
  assign ctl.ref_ready = ready_q;
endmodule

// >>> verilog/dar_top.sv
/*
  dual channel simultaneous-sampling converter: digital control and
  serial readout of the previous result pair.
  assumes the converter front end presents each channel as a straight
  binary word on sys_clk, and the host drives strobe and shift clock pins.
*/
`timescale 1ns/1ns
`include "dar_consts.svh"

module dar_top #(
  parameter int unsigned SETTLE_CYCLES = `DAR_SETTLE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // host pins
  input wire logic convert_strobe,
  input wire logic shift_clk,
  output logic serial_result_out,
  output logic serial_result_oe,
  // converter front end
  input wire dar_pkg::dar_word_type input_pair_a,
  input wire dar_pkg::dar_word_type input_pair_b,
  // status
  output logic acquiring,
  output logic light_pd,
  output logic deep_pd,
  output logic ref_ready
);
  import dar_pkg::*;

  // ==========================================================
  // declarations
  dar_ctl_if ctl ();

  logic [2:0] strobe_sync_q; // two-stage sync plus edge stage
  logic [2:0] shift_sync_q;
  dar_word_type hold_a_q, hold_b_q; // sample being converted
  dar_word_type result_a_q, result_b_q; // last finished conversion
  logic busy_q; // a conversion is running
  logic [`DAR_BITCNT_W-1:0] edge_cnt_q; // shift edges since start
  logic [`DAR_FRAME_BITS-1:0] shreg_q; // bits still to present
  logic [`DAR_BITCNT_W-1:0] bits_left_q;
  logic bit_q, oe_q, acq_q;
  logic light_q, deep_q, ready_q;

  // place one result in its half-frame, pad slots low
  function automatic logic [`DAR_HALF_BITS-1:0] dar_half(input dar_word_type w);
    dar_half = {w, {`DAR_PAD_BITS{1'b0}}};
  endfunction

  wire logic strobe_rise; // one cycle per strobe rising edge
  wire logic shift_rise;  // one cycle per shift rising edge
  wire logic awake;       // power state allows conversion
  wire logic start;       // accepted conversion start
  wire logic late;        // start and shift edge too close together
  wire logic advance;     // shift edge that moves the sequence
  wire logic finish;      // final conversion edge
  wire logic [`DAR_FRAME_BITS-1:0] frame; // previous pair, packed

  // ==========================================================
  // edge decode from the second sync stage against the edge stage
  assign strobe_rise = strobe_sync_q[1] & ~strobe_sync_q[2];
  assign shift_rise = shift_sync_q[1] & ~shift_sync_q[2];
  assign ctl.strobe_rise = strobe_rise;
  assign ctl.shift_rise = shift_rise;

  // a strobe in light power-down is a nap or sleep request, not a start;
  // once a shift edge wakes the part the very next strobe converts
  assign awake = (ctl.pwr_state == dar_st_active);
  assign start = strobe_rise & awake;
  // both edges inside one sample period means setup below the minimum
  assign late = start & shift_rise;
  // the late edge is swallowed; otherwise every shift edge counts
  assign advance = shift_rise & ~late;
  assign finish = advance & busy_q & (edge_cnt_q == `DAR_FRAME_LEN_M1);
  // channel a in the first half, channel b in the second
  assign frame = {dar_half(result_a_q), dar_half(result_b_q)};

  // ==========================================================
  // power-state tracker
  dar_power #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_power (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ctl(ctl)
  );

  // ==========================================================
  // pin synchronisers: pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_sync_q <= 3'h0;
      shift_sync_q <= 3'h0;
    end else begin
      strobe_sync_q <= {strobe_sync_q[1:0], convert_strobe};
      shift_sync_q <= {shift_sync_q[1:0], shift_clk};
    end
  end

  // ==========================================================
  // sample hold: both channels caught in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_a_q <= '0;
      hold_b_q <= '0;
    end else if (start) begin
      hold_a_q <= input_pair_a;
      hold_b_q <= input_pair_b;
    end
  end

  // ==========================================================
  // conversion sequencer; a restart mid-conversion drops the old sample
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      edge_cnt_q <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      edge_cnt_q <= '0;
    end else if (finish) begin
      busy_q <= 1'b0;
      edge_cnt_q <= `DAR_DONE_EDGES;
    end else if (advance && busy_q) begin
      edge_cnt_q <= edge_cnt_q + `DAR_BITCNT_W'(1);
    end
  end

  // finished results become the next frame's content
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      result_a_q <= '0;
      result_b_q <= '0;
    end else if (finish) begin
      result_a_q <= hold_a_q;
      result_b_q <= hold_b_q;
    end
  end

  // acquisition window: opens on the last conversion edge, shuts on strobe;
  // the opening edge wins when both land in one cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acq_q <= 1'b0;
    end else if (finish) begin
      acq_q <= 1'b1;
    end else if (strobe_rise) begin
      acq_q <= 1'b0;
    end
  end

  // ==========================================================
  // serial output: first bit ready at start, next bit on each shift edge;
  // a late start presents a low dummy first so data comes one edge later
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shreg_q <= '0;
      bits_left_q <= '0;
      bit_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (!awake) begin
      // no readout while powered down; line released
      bits_left_q <= '0;
      bit_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (start && late) begin
      shreg_q <= frame;
      bits_left_q <= `DAR_FRAME_LEN;
      bit_q <= 1'b0;
      oe_q <= 1'b1;
    end else if (start) begin
      shreg_q <= {frame[`DAR_FRAME_BITS-2:0], 1'b0};
      bits_left_q <= `DAR_FRAME_LEN_M1;
      bit_q <= frame[`DAR_FRAME_BITS-1];
      oe_q <= 1'b1;
    end else if (advance && oe_q) begin
      if (bits_left_q == '0) begin
        bit_q <= 1'b0;
        oe_q <= 1'b0;
      end else begin
        bit_q <= shreg_q[`DAR_FRAME_BITS-1];
        shreg_q <= {shreg_q[`DAR_FRAME_BITS-2:0], 1'b0};
        bits_left_q <= bits_left_q - `DAR_BITCNT_W'(1);
      end
    end
  end

  // ==========================================================
  // status flags re-registered so every output leaves a flip-flop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      light_q <= 1'b0;
      deep_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      light_q <= (ctl.pwr_state == dar_st_nap);
      deep_q <= (ctl.pwr_state == dar_st_sleep) || (ctl.pwr_state == dar_st_waking);
      ready_q <= ctl.ref_ready;
    end
  end

  assign serial_result_out = bit_q;
  assign serial_result_oe = oe_q;
  assign acquiring = acq_q;
  assign light_pd = light_q;
  assign deep_pd = deep_q;
  assign ref_ready = ready_q;
endmodule

// >>> testbench/dar_top_asserts.sv
/* port checker for the dual channel readout top.
   assumes three-edge pin sync and SETTLE_CYCLES handed on by the bind. */
`timescale 1ns/1ns

module dar_top_chk #(
  parameter int unsigned SETTLE_CYCLES = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // host pins
  input wire logic convert_strobe,
  input wire logic shift_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  // status
  input wire logic acquiring,
  input wire logic light_pd,
  input wire logic deep_pd,
  input wire logic ref_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // settle count: cycles with the reference off outside deep
  logic [16:0] wait_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) wait_q <= 17'h0;
    else wait_q <= (ref_ready || deep_pd) ? 17'h0 : wait_q + 17'h1;
  end
  // ==========================================================
  // pin to output and output to output relations
  oe_cause_a: assert property ($rose(serial_result_oe) |-> $past(convert_strobe, 3) && !$past(convert_strobe, 4))
    else $error("oe rose without strobe");
  bit_hold_a: assert property (serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out) |->
    ($past(shift_clk, 3) && !$past(shift_clk, 4)) || ($past(convert_strobe, 3) && !$past(convert_strobe, 4)))
    else $error("data moved without an edge");
  idle_low_a: assert property (!serial_result_oe |-> !serial_result_out)
    else $error("data high while released");
  pd_quiet_a: assert property (light_pd || deep_pd |-> !serial_result_oe)
    else $error("driving in power-down");
  pd_excl_a: assert property (!(light_pd && deep_pd))
    else $error("both power-downs");
  deep_exit_a: assert property ($fell(deep_pd) |-> light_pd && !ref_ready)
    else $error("deep left without nap");
  ref_settle_a: assert property ($rose(ref_ready) |-> wait_q + 1 >= SETTLE_CYCLES && wait_q <= SETTLE_CYCLES + 1)
    else $error("settle time wrong");
  acq_end_a: assert property ($rose(convert_strobe) && acquiring && !light_pd && !deep_pd |-> ##3 !acquiring)
    else $error("acquire not ended");
  nap_wake_a: assert property ($rose(shift_clk) && light_pd && !$rose(convert_strobe) |-> ##4 !light_pd)
    else $error("nap not left");
  deep_hold_a: assert property ($rose(shift_clk) && deep_pd |-> ##4 deep_pd)
    else $error("deep left on shift");
endmodule

bind dar_top dar_top_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_dar_top_chk (.sys_clk, .resetn, .convert_strobe,
  .shift_clk, .serial_result_out, .serial_result_oe, .acquiring, .light_pd, .deep_pd, .ref_ready);

// >>> testbench/dar_host_model.sv
/* host model: drives strobe and shift clock at the falling edge and
   captures the line on each frame shift rise, the first two of a late frame excepted. assumes a 40 ns sys_clk. */
`timescale 1ns/1ns

module dar_host_model (
  // clock
  input wire logic sys_clk,
  // pins
  output logic convert_strobe,
  output logic shift_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  // captured frame
  output logic [31:0] frame_word,
  output logic frame_done
);
  logic line_q; // a released line shows the inverse of its last level
  int half_q; // cycles each shift clock level stands during a frame
  initial begin
    half_q = 4;
    convert_strobe = 1'b0;
    shift_clk = 1'b0;
    frame_done = 1'b0;
    frame_word = 32'h0;
    line_q = 1'b0;
  end
  // ==========================================================
  // pin levels stand four cycles, above the two the sync needs
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic pulse_strobe();
    convert_strobe = 1'b1;
    hold(4);
    convert_strobe = 1'b0;
    hold(4);
  endtask
  task automatic shift_pulse();
    shift_clk = 1'b1;
    hold(4);
    shift_clk = 1'b0;
    hold(4);
  endtask
  // late: strobe and first shift rise together, data one edge later,
  // so a late frame needs two extra rises to bring out all 32 bits
  task automatic frame(input bit late, input int rises);
    frame_word = 32'h0;
    convert_strobe = 1'b1;
    if (!late) hold(4);
    for (int k = 1; k <= rises; k++) begin
      if (k > (late ? 2 : 0)) begin
        line_q = serial_result_oe ? serial_result_out : ~line_q;
        frame_word = {frame_word[30:0], line_q};
      end
      shift_clk = 1'b1;
      hold(half_q);
      convert_strobe = 1'b0;
      shift_clk = 1'b0;
      hold(half_q);
    end
    if (rises >= 32) begin
      frame_done = 1'b1;
      hold(1);
      frame_done = 1'b0;
    end
  endtask
endmodule

// >>> testbench/dual_adc_serial_readout_bench.sv
/* self-checking bench: frames, restart, late strobe, light and deep power-down.
   assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module dual_adc_serial_readout_bench;
  import dar_pkg::*;
  // ==========================================================
  // signals
  logic sys_clk, resetn, convert_strobe, shift_clk, serial_result_out, serial_result_oe;
  logic acquiring, light_pd, deep_pd, ref_ready, frame_done;
  dar_word_type input_pair_a, input_pair_b;
  logic [31:0] frame_word, prev_w, mon_exp;
  logic [31:0] exp_q[$]; // expected frames, oldest first
  int fail_count, compares;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // short settle keeps the run brief
  dar_top #(.SETTLE_CYCLES(20)) u_dar_top (.sys_clk, .resetn, .convert_strobe, .shift_clk, .serial_result_out,
    .serial_result_oe, .input_pair_a, .input_pair_b, .acquiring, .light_pd, .deep_pd, .ref_ready);
  dar_host_model u_dar_host_model (.sys_clk, .convert_strobe, .shift_clk, .serial_result_out,
    .serial_result_oe, .frame_word, .frame_done);
  // ==========================================================
  // tasks
  task automatic results();
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // frames read back the pair of the previous finished conversion
  task automatic run(input bit late, input int rises, input dar_word_type a, input dar_word_type b);
    input_pair_a = a;
    input_pair_b = b;
    if (rises >= 32) exp_q.push_back(prev_w);
    u_dar_host_model.frame(late, rises);
    if (rises >= 32) begin
      prev_w = {a, 2'h0, b, 2'h0};
      `CHECK("acquiring", 1'b1, acquiring)
      `CHECK("oe after frame", 1'b0, serial_result_oe)
    end
  endtask
  task automatic check_pd(input logic [1:0] ex);
    `CHECK("power state", ex, {light_pd, deep_pd})
  endtask
  // ==========================================================
  // monitor: oldest note against each captured frame
  always @(posedge frame_done) begin
    mon_exp = exp_q.size() > 0 ? exp_q.pop_front() : 32'hx;
    `CHECK("frame", mon_exp, frame_word)
  end
  // ==========================================================
  // main sequence
  initial begin
    resetn = 1'b0;
    input_pair_a = 14'h0;
    input_pair_b = 14'h0;
    prev_w = 32'h0;
    fail_count = 0;
    compares = 0;
    void'($urandom(15604));
    hold(8);
    `CHECK("ref_ready", 1'b1, ref_ready)
    check_pd(2'b00);
    resetn = 1'b1;
    hold(2);
    // back-to-back frames with full-scale, zero and one late start
    for (int i = 0; i < 6; i++) begin
      run(i == 3, i == 3 ? 34 : 32, i == 1 ? 14'h3fff : dar_word_type'($urandom),
        i == 2 ? 14'h0 : dar_word_type'($urandom));
    end
    // a cut-short conversion must not replace the last finished pair
    run(1'b0, 10, 14'h1555, 14'h2aaa);
    run(1'b0, 32, dar_word_type'($urandom), dar_word_type'($urandom));
    repeat (2) u_dar_host_model.pulse_strobe();
    check_pd(2'b10);
    u_dar_host_model.shift_pulse();
    check_pd(2'b00);
    run(1'b0, 32, dar_word_type'($urandom), dar_word_type'($urandom));
    repeat (4) u_dar_host_model.pulse_strobe();
    check_pd(2'b01);
    u_dar_host_model.shift_pulse();
    check_pd(2'b01);
    repeat (2) u_dar_host_model.pulse_strobe();
    check_pd(2'b10);
    `CHECK("ref_ready", 1'b0, ref_ready)
    hold(24);
    `CHECK("ref_ready", 1'b1, ref_ready)
    u_dar_host_model.shift_pulse();
    check_pd(2'b00);
    // last frame read with a stretched shift period
    u_dar_host_model.half_q = 12;
    run(1'b0, 32, dar_word_type'($urandom), dar_word_type'($urandom));
    hold(4);
    `CHECK("frames left", 0, exp_q.size())
    results();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    results();
  end
endmodule
